// File: can_core_model.sv
`timescale 1ns/1ps

// Far side of the block: the CAN core shifting bits and reporting handler events
module can_core_model
  import can_msg_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       tx_bit_in,
  output logic            rx_bit_out,
  output logic            rx_valid_out,
  output logic            rx_store_out,
  output logic [4:0]      rx_obj_out,
  output logic            tx_load_out,
  output logic            tx_adv_out,
  output logic            tx_done_out,
  output logic [4:0]      tx_obj_out,
  output logic            remote_out,
  output logic [4:0]      remote_obj_out,
  output logic            stat_upd_out,
  output status_s         stat_val_out
);
  initial
  begin
    {rx_bit_out, rx_valid_out, rx_store_out, rx_obj_out} = '0;
    {tx_load_out, tx_adv_out, tx_done_out, tx_obj_out} = '0;
    {remote_out, remote_obj_out, stat_upd_out, stat_val_out} = '0;
  end

  // Byte 0 goes first, each byte top bit first
  task automatic rx_frame(input payload_s p, input logic [4:0] obj);
    for (int i = 63; i >= 0; i--)
    begin
      @(posedge clk_in);
      rx_valid_out <= 1'b1;
      rx_bit_out   <= p[i];
    end
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_bit_out   <= ~rx_bit_out;
    rx_store_out <= 1'b1;
    rx_obj_out   <= obj;
    @(posedge clk_in);
    rx_store_out <= 1'b0;
  endtask

  task automatic tx_frame(input logic [4:0] obj, output logic [63:0] got);
    @(posedge clk_in);
    tx_load_out <= 1'b1;
    tx_obj_out  <= obj;
    @(posedge clk_in);
    tx_load_out <= 1'b0;
    tx_adv_out  <= 1'b1;
    for (int i = 63; i > 0; i--)
    begin
      #1 got[i] = tx_bit_in;
      @(posedge clk_in);
    end
    tx_adv_out <= 1'b0;
    #1 got[0] = tx_bit_in;
  endtask

  task automatic done(input logic [4:0] obj);
    @(posedge clk_in);
    tx_done_out <= 1'b1;
    tx_obj_out  <= obj;
    @(posedge clk_in);
    tx_done_out <= 1'b0;
  endtask

  task automatic remote(input logic [4:0] obj);
    @(posedge clk_in);
    remote_out     <= 1'b1;
    remote_obj_out <= obj;
    @(posedge clk_in);
    remote_out <= 1'b0;
  endtask

  task automatic stat(input status_s val);
    @(posedge clk_in);
    stat_upd_out <= 1'b1;
    stat_val_out <= val;
    @(posedge clk_in);
    stat_upd_out <= 1'b0;
    stat_val_out <= ~val;
  endtask
endmodule

// File: can_msg_interrupt_and_data.sv
`timescale 1ns/1ps
`include "can_msg_params.svh"

module can_msg_interrupt_and_data
  import can_msg_pkg::*;
#(
  parameter int NUM_OBJ = 32
)
(
  input  wire logic                       clk_in,
  input  wire logic                       reset_n_in,
  input  wire logic                       ce_in,
  input  wire bus_req_s                   reg_req_in,
  output logic      [7:0]                 rd_data_out,
  input  wire logic                       rx_bit_in,
  input  wire logic                       rx_bit_valid_in,
  input  wire logic                       rx_store_in,
  input  wire logic [$clog2(NUM_OBJ)-1:0] rx_obj_in,
  input  wire logic                       tx_load_in,
  input  wire logic                       tx_bit_adv_in,
  input  wire logic                       tx_done_in,
  input  wire logic [$clog2(NUM_OBJ)-1:0] tx_obj_in,
  output logic                            tx_bit_out,
  input  wire logic                       remote_rx_in,
  input  wire logic [$clog2(NUM_OBJ)-1:0] remote_obj_in,
  input  wire logic                       status_update_in,
  input  wire status_s                    status_val_in,
  output logic                            irq_out
);

  localparam int IDXW = $clog2(NUM_OBJ);

  payload_s             obj_data_r [NUM_OBJ];
  payload_s             buf_r;
  logic [63:0]          rx_shift_r;
  logic [63:0]          tx_shift_r;
  logic [NUM_OBJ-1:0]   pend_r;
  logic [NUM_OBJ-1:0]   transmit_request_bit_r;
  logic [NUM_OBJ-1:0]   ndat_r;
  logic [7:0]           ctrl_r;
  logic [7:0]           cfg_r;
  status_s              status_r;
  logic                 status_pnd_r;
  logic [7:0]           obj_num_r;
  logic [15:0]          interrupt_identifier_r;
  logic [15:0]          interrupt_identifier_nxt;
  logic                 irq_r;
  logic                 irq_nxt;
  logic [7:0]           rd_data_r;
  logic [7:0]           rd_data_nxt;
  logic                 cmd_wr;
  logic                 obj_ok;
  logic [IDXW-1:0]      cmd_idx;
  logic [7:0]           obj_num_m1;
  logic                 stat_rd;
  logic                 stat_wr;
  logic                 ie_w;
  logic                 pol_w;
  logic                 act_w;
  logic [31:0]          pend_vec;
  logic [31:0]          transmit_request_bit_vec;
  logic [31:0]          ndat_vec;

  assign ie_w       = ctrl_r[`CTRL_IE_BIT];
  assign pol_w      = cfg_r[`CFG_POL_BIT];
  assign act_w      = (interrupt_identifier_r != `INTERRUPT_IDENTIFIER_NONE) && ie_w;
  assign stat_rd    = reg_req_in.rd && (reg_req_in.addr == `ADDR_STAT);
  assign stat_wr    = reg_req_in.wr && (reg_req_in.addr == `ADDR_STAT);
  assign cmd_wr     = reg_req_in.wr && (reg_req_in.addr == `ADDR_CMD);
  assign obj_num_m1 = obj_num_r - 8'h01;
  assign cmd_idx    = obj_num_m1[IDXW-1:0];
  // Object numbers outside 1..NUM_OBJ make a command a no-op
  assign obj_ok     = (obj_num_r != 8'h00) && (obj_num_r <= 8'(NUM_OBJ));
  assign pend_vec   = 32'(pend_r);
  assign transmit_request_bit_vec   = 32'(transmit_request_bit_r);
  assign ndat_vec   = 32'(ndat_r);

  assign rd_data_out = rd_data_r;
  assign tx_bit_out  = tx_shift_r[63];
  assign irq_out     = irq_r;

  // Per-object storage and handler status bits
  for (genvar i = 0; i < NUM_OBJ; i++)
  begin : g_obj
    logic sel;
    logic hw_rx;
    logic hw_tx;
    logic hw_rmt;
    assign sel    = cmd_wr && obj_ok && (cmd_idx == IDXW'(i));
    assign hw_rx  = rx_store_in && (rx_obj_in == IDXW'(i));
    assign hw_tx  = tx_done_in && (tx_obj_in == IDXW'(i));
    assign hw_rmt = remote_rx_in && (remote_obj_in == IDXW'(i));

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
        obj_data_r[i] <= '0;
      else if (ce_in)
      begin
        // Whole 64-bit shift register is stored as all eight bytes of the object
        if (hw_rx)
          obj_data_r[i] <= payload_s'(rx_shift_r);
        else if (sel && reg_req_in.wdata[`CMD_WRITE_BIT])
          obj_data_r[i] <= buf_r;
      end
    end

    // Hardware set wins over a CPU clear in the same cycle
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
        pend_r[i] <= 1'b0;
      else if (ce_in)
        pend_r[i] <= hw_rx || hw_tx ||
                     (pend_r[i] && !(sel && reg_req_in.wdata[`CMD_CLRPND_BIT]));
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
        transmit_request_bit_r[i] <= 1'b0;
      else if (ce_in)
        transmit_request_bit_r[i] <= hw_rmt || (sel && reg_req_in.wdata[`CMD_SETTREQ_BIT]) ||
                     (transmit_request_bit_r[i] && !hw_tx &&
                      !(sel && reg_req_in.wdata[`CMD_CLRTREQ_BIT]));
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
        ndat_r[i] <= 1'b0;
      else if (ce_in)
        ndat_r[i] <= hw_rx || (sel && reg_req_in.wdata[`CMD_WRITE_BIT]) ||
                     (ndat_r[i] && !(sel && reg_req_in.wdata[`CMD_CLRNDAT_BIT]));
    end
  end

  // Interface buffer: data-A holds bytes 0-3, data-B bytes 4-7
  for (genvar k = 0; k < 8; k++)
  begin : g_buf
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
        buf_r.bytes[k] <= `RST_BYTE;
      else if (ce_in)
      begin
        if (cmd_wr && obj_ok && reg_req_in.wdata[`CMD_READ_BIT])
          buf_r.bytes[k] <= obj_data_r[cmd_idx].bytes[k];
        else if (reg_req_in.wr && (reg_req_in.addr == (`ADDR_DATA_BASE + 8'(k))))
          buf_r.bytes[k] <= reg_req_in.wdata;
      end
    end
  end

  // First bit received ends up at the top, so byte 0 is the first byte
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rx_shift_r <= '0;
    else if (ce_in && rx_bit_valid_in)
      rx_shift_r <= {rx_shift_r[62:0], rx_bit_in};
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      tx_shift_r <= '0;
    else if (ce_in)
    begin
      if (tx_load_in)
        tx_shift_r <= obj_data_r[tx_obj_in];
      else if (tx_bit_adv_in)
        tx_shift_r <= {tx_shift_r[62:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_r    <= `RST_BYTE;
      cfg_r     <= `RST_BYTE;
      obj_num_r <= `RST_OBJ_NUM;
    end
    else if (ce_in && reg_req_in.wr)
    begin
      if (reg_req_in.addr == `ADDR_CTRL)
        ctrl_r <= reg_req_in.wdata;
      if (reg_req_in.addr == `ADDR_CFG)
        cfg_r <= reg_req_in.wdata;
      if (reg_req_in.addr == `ADDR_OBJ_NUM)
        obj_num_r <= reg_req_in.wdata;
    end
  end

  // Core update has priority over a CPU write in the same cycle
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      status_r <= status_s'(`RST_BYTE);
    else if (ce_in)
    begin
      if (status_update_in)
        status_r <= status_val_in;
      else if (stat_wr)
        status_r <= status_s'(reg_req_in.wdata);
    end
  end

  // CPU writes never touch this flag; a new update with ie_w set wins over the read
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      status_pnd_r <= 1'b0;
    else if (ce_in)
      status_pnd_r <= (status_update_in && ie_w) ||
                      (status_pnd_r && !stat_rd);
  end

  always_comb
  begin
    interrupt_identifier_nxt = `INTERRUPT_IDENTIFIER_NONE;
    for (int j = NUM_OBJ - 1; j >= 0; j--)
    begin
      if (pend_r[j])
        interrupt_identifier_nxt = 16'(j + 1);
    end
    if (status_pnd_r)
      interrupt_identifier_nxt = `INTERRUPT_IDENTIFIER_STATUS;
  end

  // Refreshed every enabled cycle, whatever the enable bit says
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      interrupt_identifier_r <= `INTERRUPT_IDENTIFIER_NONE;
    else if (ce_in)
      interrupt_identifier_r <= interrupt_identifier_nxt;
  end

  assign irq_nxt = act_w ? pol_w : !pol_w;

  // Pin is idle-high until software picks active-high polarity
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      irq_r <= 1'b1;
    else if (ce_in)
      irq_r <= irq_nxt;
  end

  always_comb
  begin
    rd_data_nxt = `RST_BYTE;
    if (reg_req_in.addr[7:3] == `ADDR_DATA_BASE >> 3)
      rd_data_nxt = buf_r.bytes[reg_req_in.addr[2:0]];
    else if (reg_req_in.addr[7:2] == `ADDR_TRANSMIT_REQUEST_BIT_BASE >> 2)
      rd_data_nxt = transmit_request_bit_vec[8*reg_req_in.addr[1:0] +: 8];
    else if (reg_req_in.addr[7:2] == `ADDR_NDAT_BASE >> 2)
      rd_data_nxt = ndat_vec[8*reg_req_in.addr[1:0] +: 8];
    else if (reg_req_in.addr[7:2] == `ADDR_PND_BASE >> 2)
      rd_data_nxt = pend_vec[8*reg_req_in.addr[1:0] +: 8];
    else
    begin
      unique case (reg_req_in.addr)
        `ADDR_CTRL:     rd_data_nxt = ctrl_r;
        `ADDR_CFG:      rd_data_nxt = cfg_r;
        `ADDR_STAT:     rd_data_nxt = status_r;
        `ADDR_INTERRUPT_IDENTIFIER_LO: rd_data_nxt = interrupt_identifier_r[7:0];
        `ADDR_INTERRUPT_IDENTIFIER_HI: rd_data_nxt = interrupt_identifier_r[15:8];
        `ADDR_OBJ_NUM:  rd_data_nxt = obj_num_r;
        default:        rd_data_nxt = `RST_BYTE;
      endcase
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rd_data_r <= `RST_BYTE;
    else if (ce_in)
      rd_data_r <= reg_req_in.rd ? rd_data_nxt : `RST_BYTE;
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_status_top;
    ce_in && status_pnd_r |=> interrupt_identifier_r == `INTERRUPT_IDENTIFIER_STATUS;
  endproperty
  a_status_top: assert property (p_status_top)
    else $error("status interrupt not shown first");

  property p_lowest_obj;
    ce_in && !status_pnd_r && pend_r[0] |=> interrupt_identifier_r == 16'h0001;
  endproperty
  a_lowest_obj: assert property (p_lowest_obj)
    else $error("object one not given priority");

  property p_idle_zero;
    ce_in && !status_pnd_r && (pend_r == '0) |=> interrupt_identifier_r == `INTERRUPT_IDENTIFIER_NONE;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("identifier nonzero with nothing pending");

  property p_pin_level;
    ce_in |=> irq_out == ($past(act_w) ? $past(pol_w) : !$past(pol_w));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("interrupt pin level wrong");

  property p_status_sticky;
    ce_in && status_pnd_r && !stat_rd |=> status_pnd_r;
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status interrupt dropped without read");

  sequence s_stat_read;
    ce_in && stat_rd && !status_update_in;
  endsequence

  sequence s_quiet;
    ce_in && !status_update_in && (pend_r == '0);
  endsequence

  property p_read_clears;
    s_stat_read ##1 s_quiet |=> interrupt_identifier_r == `INTERRUPT_IDENTIFIER_NONE;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear identifier");

  property p_write_neutral;
    ce_in && stat_wr && !status_update_in && !stat_rd
      |=> status_pnd_r == $past(status_pnd_r);
  endproperty
  a_write_neutral: assert property (p_write_neutral)
    else $error("status write changed interrupt");

  property p_enable_gate;
    ce_in && status_update_in && !ie_w && !status_pnd_r |=> !status_pnd_r;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("status interrupt set while disabled");

  property p_update_sets;
    ce_in && status_update_in && ie_w ##1 ce_in |=> interrupt_identifier_r == `INTERRUPT_IDENTIFIER_STATUS;
  endproperty
  a_update_sets: assert property (p_update_sets)
    else $error("status update did not raise identifier");

  property p_rx_pending;
    ce_in && rx_store_in |=> pend_r[$past(rx_obj_in)] && ndat_r[$past(rx_obj_in)];
  endproperty
  a_rx_pending: assert property (p_rx_pending)
    else $error("reception did not set pending");

endmodule

// File: can_msg_params.svh
`ifndef CAN_MSG_PARAMS_SVH
`define CAN_MSG_PARAMS_SVH

// Register byte addresses
`define ADDR_CTRL       8'h01
`define ADDR_CFG        8'h02
`define ADDR_STAT       8'h03
`define ADDR_INTERRUPT_IDENTIFIER_LO   8'h08
`define ADDR_INTERRUPT_IDENTIFIER_HI   8'h09
`define ADDR_OBJ_NUM    8'h10
`define ADDR_CMD        8'h11
`define ADDR_DATA_BASE  8'h40
`define ADDR_TRANSMIT_REQUEST_BIT_BASE  8'h80
`define ADDR_NDAT_BASE  8'h90
`define ADDR_PND_BASE   8'ha0

// Field positions
`define CTRL_IE_BIT     0
`define CFG_POL_BIT     0
`define CMD_READ_BIT    0
`define CMD_WRITE_BIT   1
`define CMD_CLRPND_BIT  2
`define CMD_SETTREQ_BIT 3
`define CMD_CLRTREQ_BIT 4
`define CMD_CLRNDAT_BIT 5

// Reset values and codes
`define RST_BYTE        8'h00
`define RST_OBJ_NUM     8'h01
`define INTERRUPT_IDENTIFIER_NONE      16'h0000
`define INTERRUPT_IDENTIFIER_STATUS    16'h8000

`endif

// File: can_msg_pkg.sv
package can_msg_pkg;

  typedef logic [7:0] byte_t;

  // Byte 0 sits at the top so the vector is in serial order
  typedef struct packed {
    logic [0:7][7:0] bytes;
  } payload_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  typedef struct packed {
    logic [2:0] spare;
    logic       rx_ok;
    logic       tx_ok;
    logic [2:0] last_error_code;
  } status_s;

endpackage

// File: testbench.sv
`timescale 1ns/1ps
`include "can_msg_params.svh"

module testbench;
  import can_msg_pkg::*;
  logic        clk_in     = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        ce_in      = 1'b1;
  bus_req_s    req        = '0;
  logic [7:0]  rd_data_out;
  logic        rx_bit, rx_valid, rx_store, tx_load, tx_adv, tx_done;
  logic        tx_bit, remote, stat_upd, irq_out;
  logic [4:0]  rx_obj, tx_obj, remote_obj;
  status_s     stat_val;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cycles      = 0;
  logic [63:0] got;
  payload_s    pl;

  always #25 clk_in = ~clk_in;

  can_msg_interrupt_and_data dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .reg_req_in(req), .rd_data_out(rd_data_out), .rx_bit_in(rx_bit),
    .rx_bit_valid_in(rx_valid), .rx_store_in(rx_store), .rx_obj_in(rx_obj),
    .tx_load_in(tx_load), .tx_bit_adv_in(tx_adv), .tx_done_in(tx_done), .tx_obj_in(tx_obj),
    .tx_bit_out(tx_bit), .remote_rx_in(remote), .remote_obj_in(remote_obj),
    .status_update_in(stat_upd), .status_val_in(stat_val), .irq_out(irq_out));

  can_core_model core (.clk_in(clk_in), .tx_bit_in(tx_bit), .rx_bit_out(rx_bit),
    .rx_valid_out(rx_valid), .rx_store_out(rx_store), .rx_obj_out(rx_obj),
    .tx_load_out(tx_load), .tx_adv_out(tx_adv), .tx_done_out(tx_done), .tx_obj_out(tx_obj),
    .remote_out(remote), .remote_obj_out(remote_obj), .stat_upd_out(stat_upd),
    .stat_val_out(stat_val));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req <= '0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req <= '0;
    #1 d = rd_data_out;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    check(d, exp);
  endtask

  // Identifier is read live, low byte then high byte
  task automatic id_check(input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    reg_read(`ADDR_INTERRUPT_IDENTIFIER_LO, lo);
    reg_read(`ADDR_INTERRUPT_IDENTIFIER_HI, hi);
    check({hi, lo}, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  function automatic byte_t buf_byte(input int i);
    return 8'h80 + 8'(17 * i);
  endfunction

  initial
  begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    id_check(16'h0000);
    read_check(`ADDR_PND_BASE, 8'h00);
    read_check(`ADDR_TRANSMIT_REQUEST_BIT_BASE, 8'h00);
    read_check(8'h3f, 8'h00);
    check({15'h0000, irq_out}, 16'h0001);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
      reg_write(`ADDR_DATA_BASE + 8'(i), buf_byte(i));
    for (int i = 0; i < 8; i++)
      read_check(`ADDR_DATA_BASE + 8'(i), buf_byte(i));
    reg_write(`ADDR_OBJ_NUM, 8'h03);
    reg_write(`ADDR_CMD, 8'h02);
    core.tx_frame(5'd2, got);
    for (int i = 0; i < 8; i++)
      check(got[63 - 8 * i -: 8], buf_byte(i));
    core.done(5'd2);
    idle(3);
    read_check(`ADDR_PND_BASE, 8'h04);
    id_check(16'h0003);
    $display("test transmit done");
    pl = 64'h0123_4567_89ab_cdef;
    core.rx_frame(pl, 5'd0);
    idle(3);
    read_check(`ADDR_PND_BASE, 8'h05);
    id_check(16'h0001);
    reg_write(`ADDR_OBJ_NUM, 8'h01);
    reg_write(`ADDR_CMD, 8'h05);
    idle(3);
    for (int i = 0; i < 8; i++)
      read_check(`ADDR_DATA_BASE + 8'(i), pl.bytes[i]);
    id_check(16'h0003);
    $display("test receive done");
    check({15'h0000, irq_out}, 16'h0001);
    reg_write(`ADDR_CTRL, 8'h01);
    idle(3);
    check({15'h0000, irq_out}, 16'h0000);
    reg_write(`ADDR_CFG, 8'h01);
    idle(3);
    check({15'h0000, irq_out}, 16'h0001);
    core.stat(8'h15);
    idle(3);
    id_check(16'h8000);
    reg_write(`ADDR_STAT, 8'h00);
    idle(100);
    id_check(16'h8000);
    read_check(`ADDR_STAT, 8'h00);
    idle(3);
    id_check(16'h0003);
    reg_write(`ADDR_OBJ_NUM, 8'h03);
    reg_write(`ADDR_CMD, 8'h04);
    idle(3);
    id_check(16'h0000);
    check({15'h0000, irq_out}, 16'h0000);
    // Status read with no object pending must bring the identifier back to zero
    core.stat(8'h02);
    idle(3);
    read_check(`ADDR_STAT, 8'h02);
    idle(2);
    id_check(16'h0000);
    check({15'h0000, irq_out}, 16'h0000);
    reg_write(`ADDR_STAT, 8'h07);
    idle(3);
    id_check(16'h0000);
    reg_write(`ADDR_CTRL, 8'h00);
    core.stat(8'h00);
    idle(3);
    id_check(16'h0000);
    core.done(5'd4);
    idle(3);
    id_check(16'h0005);
    check({15'h0000, irq_out}, 16'h0000);
    $display("test interrupt done");
    core.remote(5'd9);
    idle(2);
    read_check(`ADDR_TRANSMIT_REQUEST_BIT_BASE + 8'h01, 8'h02);
    core.remote(5'd17);
    idle(2);
    read_check(`ADDR_TRANSMIT_REQUEST_BIT_BASE + 8'h02, 8'h02);
    core.done(5'd9);
    idle(2);
    read_check(`ADDR_TRANSMIT_REQUEST_BIT_BASE + 8'h01, 8'h00);
    reg_write(`ADDR_OBJ_NUM, 8'h20);
    reg_write(`ADDR_CMD, 8'h08);
    read_check(`ADDR_TRANSMIT_REQUEST_BIT_BASE + 8'h03, 8'h80);
    reg_write(`ADDR_CMD, 8'h10);
    read_check(`ADDR_TRANSMIT_REQUEST_BIT_BASE + 8'h03, 8'h00);
    reg_write(`ADDR_TRANSMIT_REQUEST_BIT_BASE, 8'hff);
    read_check(`ADDR_TRANSMIT_REQUEST_BIT_BASE, 8'h00);
    reg_write(`ADDR_INTERRUPT_IDENTIFIER_LO, 8'hff);
    id_check(16'h0005);
    read_check(`ADDR_NDAT_BASE, 8'h05);
    reg_write(`ADDR_OBJ_NUM, 8'h01);
    reg_write(`ADDR_CMD, 8'h20);
    read_check(`ADDR_NDAT_BASE, 8'h04);
    $display("test request done");
    // With the clock enable low, neither a handler event nor a CPU write may land
    @(posedge clk_in);
    ce_in <= 1'b0;
    core.done(5'd0);
    reg_write(`ADDR_CTRL, 8'h01);
    ce_in <= 1'b1;
    id_check(16'h0005);
    check({15'h0000, irq_out}, 16'h0000);
    $display("test enable done");
    complete_run();
  end
endmodule
